// file: design/drs_pkg.sv
package drs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRIO = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CHG = 8'h0C;
  localparam logic [7:0] OFF_LB = 8'h10;
  // Reference codes
  localparam logic [1:0] REF_NONE = 2'h0;
  localparam logic [1:0] REF_A = 2'h1;
  localparam logic [1:0] REF_B = 2'h2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] PRIO_A_RST = 4'h1;
  localparam logic [3:0] PRIO_B_RST = 4'h2;
  localparam logic [3:0] PRIO_OFF = 4'h0;
  localparam logic [7:0] LB_UP_RST = 8'h08;
  localparam logic [7:0] LB_LO_RST = 8'h01;
  // Field positions outside the structs
  localparam int unsigned CHG_SELECTED_REF_FAILED_FLAG_BIT = 4;
  localparam int unsigned LB_LO_LSB = 8;
  localparam int unsigned PRIO_B_LSB = 4;
  // Rank codes: lower is better
  localparam logic [4:0] RANK_FORCED = 5'h00;
  localparam logic [4:0] RANK_NONE = 5'h1F;
  // Frequency limit below which switching is slope limited
  localparam logic [7:0] PPM_LIMIT = 8'h1E;
  // Missing-cycle limits per frequency band
  localparam logic [4:0] MISS_BAND0 = 5'h02;
  localparam logic [4:0] MISS_BAND1 = 5'h04;
  localparam logic [4:0] MISS_BAND2 = 5'h08;
  localparam logic [4:0] MISS_BAND3 = 5'h10;
  // Phase slope window and step
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SLOPE_WINDOW_NS = 1326000;
  localparam int unsigned SLOPE_STEP_NS = 81;
  localparam int unsigned SLOPE_WINDOW_CYC_DEF = SLOPE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOPE_STEP_CYC =
    (SLOPE_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 : SLOPE_STEP_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] rsvdD;
    logic [7:0] freqLim;
    logic [1:0] bandB;
    logic [1:0] bandA;
    logic rsvdC;
    logic phase_buildout_enable;
    logic [1:0] sqEn;
    logic [1:0] rsvdB;
    logic [1:0] forceSel;
    logic rsvdA;
    logic pin_select_mode_enable;
    logic ultrafast_switch_enable;
    logic return_to_best_enable;
  } drs_ctrl_t;

  typedef struct packed {
    logic [1:0] top;
    logic [1:0] sel;
  } drs_selstat_t;

  typedef struct packed {
    logic [10:0] rsvdD;
    logic phaseLim;
    logic [1:0] rsvdC;
    logic [1:0] actAlarm;
    logic [5:0] rsvdB;
    logic [1:0] sel;
    logic [1:0] rsvdA;
    logic [1:0] top;
    logic [1:0] rsvd0;
    logic [1:0] valid;
  } drs_stat_t;
endpackage

// file: design/drs_ref_selector.sv
// Function
// RULE1: Squelch enable per input; squelch pin A kills input A, pin B kills B.
// RULE2: Priority zero disables an input; it is never selectable.
// RULE3: Priority 1 is best, priority 15 is worst.
// RULE4: Reset gives input A priority 1 and input B priority 2.
// RULE5: Automatic mode selects the best-ranked input that is valid right now.
// RULE6: Status register shows top valid entry and the selected reference.
// RULE7: Equal priorities follow a circular list; failed members are skipped.
// RULE8: Equal-priority switching is nonrevertive; return_to_best_enable is ignored among ties.
// RULE9: Revertive mode switches at once to a better newly valid input.
// RULE10: Nonrevertive mode only updates the top entry, selection stays.
// RULE11: Selected reference invalid means switch to best valid input.
// RULE12: Input becoming valid sets its latched change bit.
// RULE13: Software pulses return_to_best_enable to make a planned switch in nonrevertive mode.
// RULE14: Force field zero is automatic; nonzero gives that input top rank.
// RULE15: Ultra-fast mode fills the bucket, switches, sets selected-failed flag.
// RULE16: Ultra-fast switch sends the loop straight to prelocked 2.
// RULE17: Software should keep nonrevertive mode while ultra-fast is on.
// RULE18: Pin-select mode: pin high picks A, low picks B, validity ignored.
// RULE19: Pin-select mode drives only the selected field; top stays automatic.
// RULE20: Software must give both inputs nonzero priority in pin-select mode.
// RULE21: Build-out or limit below 30ppm keeps phase slope under 81ns/1.326ms.
// RULE22: Fast monitor fails after 2, 4, 8 or 16 missing cycles by band.
// RULE23: Bucket at alarm threshold sets activity alarm and invalidates input.
//
// Our own choices: the APB interface to the registers and the address map.
module drs_ref_selector #(
  parameter int unsigned SLOPE_WINDOW_CYC = drs_pkg::SLOPE_WINDOW_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic squelchPinA,
  input wire logic squelchPinB,
  input wire logic selectPin,
  // Input monitors, same clock
  input wire logic [1:0] monValid,
  input wire logic [1:0] actFill,
  input wire logic [1:0] actLeak,
  input wire logic [4:0] missCount,
  // Loop side
  output logic [1:0] selected_ref_field,
  output logic selRefValid,
  output logic refSwitch,
  output logic ufSwitch,
  output logic selected_ref_failed_flag,
  output logic phaseLimit,
  output logic slopeTick
);
  localparam int unsigned WIN_W = $clog2(SLOPE_WINDOW_CYC + 1);

  logic [1:0] rstSync_reg;
  logic rstN;
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  drs_pkg::drs_ctrl_t ctrl_reg;
  logic [7:0] prio_reg;
  logic [15:0] lb_reg;
  logic [1:0] chg_reg;
  logic selected_ref_failed_flag_reg;
  logic [1:0] sel_reg;
  logic [1:0] usablePrev_reg;
  logic fastFailPrev_reg;
  logic ufPending_reg;
  logic [7:0] acc_reg [2];
  logic [1:0] actAlarm_reg;
  logic [WIN_W-1:0] win_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic selValid_reg;
  logic refSwitch_reg;
  logic ufSwitch_reg;
  logic phaseLimit_reg;
  logic slopeTick_reg;

  logic [1:0] usable;
  logic [1:0] squelch;
  logic [4:0] rankA;
  logic [4:0] rankB;
  logic [4:0] topRank;
  logic [4:0] selRank;
  drs_pkg::drs_selstat_t selStat;
  logic [1:0] sel_next;
  logic fastFail;
  logic failEvt;
  logic setup;
  logic wrEn;
  logic mapped;
  logic [31:0] rdMux;
  drs_pkg::drs_stat_t stat;

  function automatic logic [4:0] rankOf(input logic [3:0] prio, input logic forced,
                                        input logic ok);
    rankOf = !ok ? drs_pkg::RANK_NONE
           : forced ? drs_pkg::RANK_FORCED // RULE14
           : {1'b0, prio}; // RULE3
  endfunction

  function automatic logic [4:0] missLimit(input logic [1:0] band);
    case (band)
      2'h0: missLimit = drs_pkg::MISS_BAND0; // RULE22
      2'h1: missLimit = drs_pkg::MISS_BAND1; // RULE22
      2'h2: missLimit = drs_pkg::MISS_BAND2; // RULE22
      default: missLimit = drs_pkg::MISS_BAND3; // RULE22
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rstSync_reg <= 2'h0;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rstN = rstSync_reg[1];

  // Pins are asynchronous; only the second stage is read
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinMeta_reg <= 3'h0;
      pinSync_reg <= 3'h0;
    end
    else
    begin
      pinMeta_reg <= {selectPin, squelchPinB, squelchPinA};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Validity of each input
  assign squelch = ctrl_reg.sqEn & pinSync_reg[1:0]; // RULE1
  assign usable[0] = (prio_reg[3:0] != drs_pkg::PRIO_OFF) && monValid[0] // RULE2
                     && !actAlarm_reg[0] && !squelch[0]; // RULE23
  assign usable[1] = (prio_reg[7:4] != drs_pkg::PRIO_OFF) && monValid[1] // RULE2
                     && !actAlarm_reg[1] && !squelch[1]; // RULE23

  assign rankA = rankOf(prio_reg[3:0], ctrl_reg.forceSel == drs_pkg::REF_A, usable[0]);
  assign rankB = rankOf(prio_reg[7:4], ctrl_reg.forceSel == drs_pkg::REF_B, usable[1]);

  // Priority table and selection
  always_comb
  begin
    selStat.top = drs_pkg::REF_NONE;
    topRank = drs_pkg::RANK_NONE;
    if (rankA < rankB)
    begin
      selStat.top = drs_pkg::REF_A; // RULE5
      topRank = rankA;
    end
    else if (rankB < rankA)
    begin
      selStat.top = drs_pkg::REF_B; // RULE5
      topRank = rankB;
    end
    else if (rankA != drs_pkg::RANK_NONE)
    begin
      // Tie: keep the current member, else the list head
      selStat.top = (sel_reg == drs_pkg::REF_B) ? drs_pkg::REF_B : drs_pkg::REF_A; // RULE7
      topRank = rankA;
    end
    selRank = drs_pkg::RANK_NONE;
    if (sel_reg == drs_pkg::REF_A)
      selRank = rankA;
    else if (sel_reg == drs_pkg::REF_B)
      selRank = rankB;
    if (ctrl_reg.pin_select_mode_enable)
      sel_next = pinSync_reg[2] ? drs_pkg::REF_A : drs_pkg::REF_B; // RULE18
    else if (selRank == drs_pkg::RANK_NONE)
      sel_next = selStat.top; // RULE11
    // Strictly better only, so ties never return_to_best_enable
    else if (ctrl_reg.return_to_best_enable && (topRank < selRank))
      sel_next = selStat.top; // RULE9 RULE8
    else
      sel_next = sel_reg; // RULE10
    selStat.sel = sel_reg;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      sel_reg <= drs_pkg::REF_NONE;
    else
      sel_reg <= sel_next; // RULE19
  end

  // Fast activity failure on the selected input
  assign fastFail = (sel_reg == drs_pkg::REF_A) ? (missCount >= missLimit(ctrl_reg.bandA))
                  : (sel_reg == drs_pkg::REF_B) ? (missCount >= missLimit(ctrl_reg.bandB))
                  : 1'b0; // RULE22
  assign failEvt = fastFail && !fastFailPrev_reg;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      fastFailPrev_reg <= 1'b0;
      ufPending_reg <= 1'b0;
    end
    else
    begin
      fastFailPrev_reg <= fastFail;
      if (sel_next != sel_reg)
        ufPending_reg <= 1'b0;
      else if (failEvt && ctrl_reg.ultrafast_switch_enable)
        ufPending_reg <= 1'b1; // RULE16
    end
  end

  // Activity buckets, one per input
  for (genvar i = 0; i < 2; i++)
  begin : gBucket
    always_ff @(posedge clk or negedge rstN)
    begin
      if (!rstN)
      begin
        acc_reg[i] <= 8'h00;
        actAlarm_reg[i] <= 1'b0;
      end
      else
      begin
        if (ctrl_reg.ultrafast_switch_enable && failEvt && (sel_reg == 2'(i + 1)))
          acc_reg[i] <= lb_reg[7:0]; // RULE15
        else if (actFill[i] && (acc_reg[i] < lb_reg[7:0]))
          acc_reg[i] <= acc_reg[i] + 8'h01;
        else if (actLeak[i] && !actFill[i] && (acc_reg[i] != 8'h00))
          acc_reg[i] <= acc_reg[i] - 8'h01;
        if (acc_reg[i] >= lb_reg[7:0])
          actAlarm_reg[i] <= 1'b1; // RULE23
        else if (acc_reg[i] <= lb_reg[15:8])
          actAlarm_reg[i] <= 1'b0;
      end
    end
  end

  // Phase slope window for the loop
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      win_reg <= '0;
      slopeTick_reg <= 1'b0;
      phaseLimit_reg <= 1'b0;
    end
    else
    begin
      phaseLimit_reg <= ctrl_reg.phase_buildout_enable || (ctrl_reg.freqLim < drs_pkg::PPM_LIMIT); // RULE21
      slopeTick_reg <= 1'b0;
      if (win_reg == WIN_W'(SLOPE_WINDOW_CYC - 1))
      begin
        win_reg <= '0;
        slopeTick_reg <= phaseLimit_reg; // RULE21
      end
      else
      begin
        win_reg <= win_reg + 1'b1;
      end
    end
  end

  // Loop-facing outputs
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      selValid_reg <= 1'b0;
      refSwitch_reg <= 1'b0;
      ufSwitch_reg <= 1'b0;
      usablePrev_reg <= 2'h0;
    end
    else
    begin
      selValid_reg <= (sel_next == drs_pkg::REF_A) ? usable[0]
                    : (sel_next == drs_pkg::REF_B) ? usable[1] : 1'b0;
      refSwitch_reg <= sel_next != sel_reg;
      ufSwitch_reg <= (sel_next != sel_reg) && ufPending_reg; // RULE16
      usablePrev_reg <= usable;
    end
  end

  // APB: zero-wait, answer in the access phase
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pready_reg && pwrite;
  assign mapped = (paddr == drs_pkg::OFF_CTRL) || (paddr == drs_pkg::OFF_PRIO)
               || (paddr == drs_pkg::OFF_STAT) || (paddr == drs_pkg::OFF_CHG)
               || (paddr == drs_pkg::OFF_LB);

  always_comb
  begin
    stat = '0;
    stat.valid = usable;
    stat.top = selStat.top; // RULE6
    stat.sel = selStat.sel; // RULE6
    stat.actAlarm = actAlarm_reg;
    stat.phaseLim = phaseLimit_reg;
    case (paddr)
      drs_pkg::OFF_CTRL: rdMux = ctrl_reg;
      drs_pkg::OFF_PRIO: rdMux = {24'h000000, prio_reg};
      drs_pkg::OFF_STAT: rdMux = stat;
      drs_pkg::OFF_CHG: rdMux = {27'h0000000, selected_ref_failed_flag_reg, 2'h0, chg_reg};
      drs_pkg::OFF_LB: rdMux = {16'h0000, lb_reg};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // Configuration registers; reserved bits stay zero
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_reg <= drs_pkg::CTRL_RST;
      prio_reg <= {drs_pkg::PRIO_B_RST, drs_pkg::PRIO_A_RST}; // RULE4
      lb_reg <= {drs_pkg::LB_LO_RST, drs_pkg::LB_UP_RST};
    end
    else if (wrEn)
    begin
      if (paddr == drs_pkg::OFF_CTRL)
      begin
        ctrl_reg <= pwdata;
        ctrl_reg.rsvdA <= 1'b0;
        ctrl_reg.rsvdB <= 2'h0;
        ctrl_reg.rsvdC <= 1'b0;
        ctrl_reg.rsvdD <= 8'h00;
      end
      if (paddr == drs_pkg::OFF_PRIO)
      begin
        prio_reg <= pwdata[7:0];
      end
      if (paddr == drs_pkg::OFF_LB)
      begin
        lb_reg <= pwdata[15:0];
      end
    end
  end

  // Sticky flags: write one clears, a new event wins
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      chg_reg <= 2'h0;
      selected_ref_failed_flag_reg <= 1'b0;
    end
    else
    begin
      chg_reg <= (chg_reg & ~((wrEn && paddr == drs_pkg::OFF_CHG) ? pwdata[1:0] : 2'h0))
                 | (usable & ~usablePrev_reg); // RULE12
      if (failEvt)
        selected_ref_failed_flag_reg <= 1'b1; // RULE15
      else if (wrEn && (paddr == drs_pkg::OFF_CHG) && pwdata[drs_pkg::CHG_SELECTED_REF_FAILED_FLAG_BIT])
        selected_ref_failed_flag_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign selected_ref_field = sel_reg;
  assign selRefValid = selValid_reg;
  assign refSwitch = refSwitch_reg;
  assign ufSwitch = ufSwitch_reg;
  assign selected_ref_failed_flag = selected_ref_failed_flag_reg;
  assign phaseLimit = phaseLimit_reg;
  assign slopeTick = slopeTick_reg;
endmodule

// file: testbench/drs_sel_monitor.sv
module drs_sel_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Loop side
  input wire logic [1:0] selected_ref_field,
  input wire logic selRefValid,
  input wire logic refSwitch,
  input wire logic ufSwitch,
  input wire logic selected_ref_failed_flag,
  input wire logic phaseLimit,
  input wire logic slopeTick
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  setup_gets_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_only_access_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready outside access");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
    else $error("no error on unmapped");
  mapped_ok_a: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h10
    |=> !pslverr)
    else $error("error on mapped");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  none_unusable_a: assert property (selected_ref_field == 2'h0 |-> !selRefValid)
    else $error("no reference but usable");
  switch_marks_a: assert property ($changed(selected_ref_field) |-> refSwitch)
    else $error("selection moved silently");
  switch_cause_a: assert property (refSwitch |-> $changed(selected_ref_field))
    else $error("switch pulse without move");
  uf_with_switch_a: assert property (ufSwitch |-> refSwitch)
    else $error("fast switch without switch");
  uf_sets_fail_a: assert property (ufSwitch |-> selected_ref_failed_flag)
    else $error("fast switch without fail flag");
  slope_when_limited_a: assert property (slopeTick |-> phaseLimit || $past(phaseLimit))
    else $error("slope tick while unlimited");
endmodule
bind drs_ref_selector drs_sel_monitor drs_sel_monitor_i (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .selected_ref_field(selected_ref_field), .selRefValid(selRefValid), .refSwitch(refSwitch), .ufSwitch(ufSwitch),
  .selected_ref_failed_flag(selected_ref_failed_flag), .phaseLimit(phaseLimit), .slopeTick(slopeTick));

// file: testbench/drs_src_model.sv
module drs_src_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Commands from the bench
  input wire logic [1:0] wantValid,
  input wire logic drop,
  // Monitor outputs
  output logic [1:0] monValid,
  output logic [1:0] actFill,
  output logic [1:0] actLeak,
  output logic [4:0] missCount
);
  logic [2:0] leakDiv;
  assign monValid = wantValid;
  assign actFill = 2'h0;
  // Steady leak so an alarm left by a fast failure drains away
  assign actLeak = {2{leakDiv == 3'h7}};
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      leakDiv <= 3'h0;
      missCount <= 5'h00;
    end
    else
    begin
      leakDiv <= leakDiv + 3'h1;
      // Stopped source: missing edges pile up, saturating
      if (drop && missCount != 5'h1F)
        missCount <= missCount + 5'h01;
      else if (!drop)
        missCount <= 5'h00;
    end
  end
endmodule

// file: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, psel, penable, pwrite, squelchPinA, squelchPinB, selectPin, drop, rdErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, selRefValid, refSwitch, ufSwitch, selected_ref_failed_flag, phaseLimit, slopeTick;
  logic [1:0] monValid, actFill, actLeak, wantValid, selected_ref_field, expSel, v;
  logic [4:0] missCount;
  logic [3:0] pa, pb;
  logic seen;
  drs_pkg::drs_stat_t st;
  int failCount, compares, seed;
  drs_ref_selector #(.SLOPE_WINDOW_CYC(16)) drs_ref_selector_i (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .squelchPinA(squelchPinA),
    .squelchPinB(squelchPinB), .selectPin(selectPin), .monValid(monValid),
    .actFill(actFill), .actLeak(actLeak), .missCount(missCount), .selected_ref_field(selected_ref_field),
    .selRefValid(selRefValid), .refSwitch(refSwitch), .ufSwitch(ufSwitch),
    .selected_ref_failed_flag(selected_ref_failed_flag), .phaseLimit(phaseLimit), .slopeTick(slopeTick));
  drs_src_model drs_src_model_i (.clk(clk), .nrst(nrst), .wantValid(wantValid), .drop(drop),
    .monValid(monValid), .actFill(actFill), .actLeak(actLeak), .missCount(missCount));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic completeRun;
    if (failCount == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; holds the request until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No fixed wait count; only the watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ckSel(input logic [1:0] e);
    // Selection lands one edge after its cause
    @(posedge clk);
    chk({30'h0, selected_ref_field}, {30'h0, e});
  endtask
  task automatic ckStat(input logic [1:0] t, input logic [1:0] s);
    apb(1'b0, 8'h08, 32'h0);
    st = rdv;
    chk({28'h0, st.top, st.sel}, {28'h0, t, s});
  endtask
  // Revertive expectation: strictly better rank wins, ties keep the current
  function automatic logic [1:0] bestRef(input logic [3:0] a, input logic [3:0] b,
    input logic [1:0] vv, input logic [1:0] cur);
    logic [4:0] ra;
    logic [4:0] rb;
    ra = (vv[0] && a != 4'h0) ? {1'b0, a} : 5'h1F;
    rb = (vv[1] && b != 4'h0) ? {1'b0, b} : 5'h1F;
    if (ra < rb)
      return drs_pkg::REF_A;
    if (rb < ra)
      return drs_pkg::REF_B;
    return (cur == drs_pkg::REF_B) ? drs_pkg::REF_B : drs_pkg::REF_A;
  endfunction
  initial
  begin
    #(50 * 20000);
    failCount++;
    completeRun;
  end
  initial
  begin
    seed = 80308;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {squelchPinA, squelchPinB, selectPin, drop} = '0;
    wantValid = 2'h3;
    failCount = 0;
    compares = 0;
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdv, {24'h0, drs_pkg::PRIO_B_RST, drs_pkg::PRIO_A_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk(rdv, {16'h0, drs_pkg::LB_LO_RST, drs_pkg::LB_UP_RST});
    apb(1'b0, 8'h14, 32'h0);
    chk({rdv[30:0], rdErr}, 32'h1);
    // Both inputs count as newly valid right after reset
    apb(1'b0, 8'h0C, 32'h0);
    chk({30'h0, rdv[1:0]}, 32'h3);
    apb(1'b1, 8'h0C, 32'h3);
    ckSel(drs_pkg::REF_A);
    ckStat(drs_pkg::REF_A, drs_pkg::REF_A);
    wantValid <= 2'h2;
    repeat (3) @(posedge clk);
    ckSel(drs_pkg::REF_B);
    wantValid <= 2'h3;
    repeat (3) @(posedge clk);
    ckStat(drs_pkg::REF_A, drs_pkg::REF_B);
    apb(1'b0, 8'h0C, 32'h0);
    chk({30'h0, rdv[1:0]}, 32'h1);
    apb(1'b1, 8'h0C, 32'h3);
    apb(1'b0, 8'h0C, 32'h0);
    chk({30'h0, rdv[1:0]}, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    ckSel(drs_pkg::REF_A);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h20);
    ckSel(drs_pkg::REF_B);
    apb(1'b1, 8'h04, 32'h21);
    apb(1'b1, 8'h00, 32'h1);
    pa = 4'h1;
    pb = 4'h2;
    expSel = drs_pkg::REF_A;
    ckSel(expSel);
    for (int i = 0; i < 40; i++)
    begin
      v = 2'h1 + 2'($unsigned($random(seed)) % 3);
      wantValid <= v;
      repeat (3) @(posedge clk);
      expSel = bestRef(pa, pb, v, expSel);
      pa = 4'h1 + 4'($unsigned($random(seed)) % 15);
      pb = 4'h1 + 4'($unsigned($random(seed)) % 15);
      apb(1'b1, 8'h04, {24'h0, pb, pa});
      repeat (2) @(posedge clk);
      expSel = bestRef(pa, pb, v, expSel);
      ckSel(expSel);
      ckStat(expSel, expSel);
    end
    apb(1'b1, 8'h04, 32'h21);
    wantValid <= 2'h3;
    apb(1'b1, 8'h00, 32'h21);
    ckStat(drs_pkg::REF_B, drs_pkg::REF_B);
    apb(1'b1, 8'h00, 32'h10);
    ckStat(drs_pkg::REF_A, drs_pkg::REF_B);
    wantValid <= 2'h1;
    repeat (3) @(posedge clk);
    ckSel(drs_pkg::REF_A);
    wantValid <= 2'h3;
    squelchPinA <= 1'b1;
    apb(1'b1, 8'h00, 32'h301);
    repeat (4) @(posedge clk);
    ckStat(drs_pkg::REF_B, drs_pkg::REF_B);
    chk({30'h0, st.valid}, 32'h2);
    squelchPinA <= 1'b0;
    squelchPinB <= 1'b1;
    repeat (5) @(posedge clk);
    ckStat(drs_pkg::REF_A, drs_pkg::REF_A);
    chk({30'h0, st.valid}, 32'h1);
    squelchPinB <= 1'b0;
    wantValid <= 2'h1;
    apb(1'b1, 8'h00, 32'h4);
    repeat (4) @(posedge clk);
    ckStat(drs_pkg::REF_A, drs_pkg::REF_B);
    selectPin <= 1'b1;
    wantValid <= 2'h2;
    repeat (5) @(posedge clk);
    ckStat(drs_pkg::REF_B, drs_pkg::REF_A);
    wantValid <= 2'h3;
    apb(1'b1, 8'h00, 32'h001D_0001);
    @(posedge clk);
    chk({31'h0, phaseLimit}, 32'h1);
    apb(1'b1, 8'h00, 32'h001E_0001);
    @(posedge clk);
    chk({31'h0, phaseLimit}, 32'h0);
    apb(1'b1, 8'h00, 32'h001E_0401);
    @(posedge clk);
    chk({31'h0, phaseLimit}, 32'h1);
    ckSel(drs_pkg::REF_A);
    apb(1'b1, 8'h00, 32'h001E_0402);
    drop <= 1'b1;
    seen = 1'b0;
    repeat (10) @(posedge clk) seen = seen | (ufSwitch === 1'b1);
    drop <= 1'b0;
    chk({30'h0, seen, selected_ref_failed_flag}, 32'h3);
    ckSel(drs_pkg::REF_B);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rdv[drs_pkg::CHG_SELECTED_REF_FAILED_FLAG_BIT]}, 32'h1);
    ckStat(drs_pkg::REF_B, drs_pkg::REF_B);
    chk({30'h0, st.actAlarm}, 32'h1);
    repeat (90) @(posedge clk);
    ckStat(drs_pkg::REF_A, drs_pkg::REF_B);
    completeRun;
  end
endmodule
